/* File: logic/timer_ctrl_pkg.sv */
// package: register map, field layout and state types of timer control
`default_nettype none
package timer_ctrl_pkg;
  // ==========================================================
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CONFIG = 8'h00; // enable, reset, guard
  localparam logic [7:0] IDX_PERIOD = 8'h01; // counter top value
  localparam logic [7:0] IDX_COUNT = 8'h02; // live count, read only
  localparam logic [7:0] IDX_STATUS = 8'h03; // running, pending
  localparam logic [7:0] IDX_CLEAR = 8'h04; // control_b_clear_access
  localparam logic [7:0] IDX_SET = 8'h05; // control_b_set_access

  // ==========================================================
  // field positions of the control byte
  localparam int CMD_LSB = 6; // command field 7:6
  localparam int SINGLE_RUN_POS = 2; // single_run_bit
  localparam int DIR_POS = 0; // direction, one counts down
  // field positions of the config byte
  localparam int CFG_ENABLE_POS = 0;
  localparam int CFG_SWRST_POS = 1;
  localparam int CFG_GUARD_POS = 2;

  // ==========================================================
  // reset values and timing counts
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] PERIOD_RESET = 8'hFF;
  localparam int unsigned PRESCALE_DIV_DEF = 4; // bus cycles per tick

  // ==========================================================
  // command codes
  typedef enum logic [1:0] {
    CMD_NONE = 2'h0,
    CMD_RETRIGGER = 2'h1,
    CMD_STOP = 2'h2,
    CMD_RESERVED = 2'h3
  } cmd_t;

  // bus handshake states, one-hot
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } bus_state_t;

  // ==========================================================
  // state carriers
  typedef struct packed {
    bus_state_t bus; // handshake phase
    logic waitreq; // registered waitrequest
    logic [31:0] rdata; // registered read data
    cmd_t cmd_pend; // command waiting for a tick
    logic single_run; // halt at next wrap
    logic dir_down; // count direction
    logic [7:0] period; // top value
    logic enable; // prescaler running
    logic guard; // write protection
    logic swrst; // one-cycle soft reset
  } main_state_t;

  typedef struct packed {
    logic [7:0] count; // prescaler count
    logic tick; // one-cycle tick
  } presc_state_t;

  typedef struct packed {
    logic [7:0] count; // timer count
    logic running; // counting enabled
  } core_state_t;
endpackage
`default_nettype wire

/* File: logic/timer_tick_prescaler.sv */
// prescaler that makes the one-cycle prescaled timer tick
`timescale 1ns/1ns
`default_nettype none
module timer_tick_prescaler #(
  parameter int unsigned DIV = timer_ctrl_pkg::PRESCALE_DIV_DEF
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic enable_in,
  input wire logic clear_in,
  output logic tick_out
);
  // ==========================================================
  // state
  localparam logic [7:0] DIV_M1 = 8'(DIV - 1); // last count
  timer_ctrl_pkg::presc_state_t st_r; // registered state
  timer_ctrl_pkg::presc_state_t st_nxt; // next state

  // next state: count to DIV_M1, then pulse tick
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (clear_in || !enable_in)
    begin
      st_nxt.count = 8'h00; // hold at start
    end
    else if (st_r.count == DIV_M1)
    begin
      st_nxt.count = 8'h00;
      st_nxt.tick = 1'b1; // one tick per DIV cycles
    end
    else
    begin
      st_nxt.count = st_r.count + 8'h01;
    end
  end

  // register the state
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign tick_out = st_r.tick;
endmodule // timer_tick_prescaler
`default_nettype wire

/* File: logic/timer_count_core.sv */
// counter core: wraps, halts in single run, obeys commands on tick
`timescale 1ns/1ns
`default_nettype none
module timer_count_core (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic tick_in,
  input wire logic clear_in,
  input wire logic retrigger_in,
  input wire logic stop_in,
  input wire logic dir_down_in,
  input wire logic single_run_in,
  input wire logic [7:0] period_in,
  output logic [7:0] count_out,
  output logic running_out
);
  // ==========================================================
  // state
  timer_ctrl_pkg::core_state_t st_r; // registered state
  timer_ctrl_pkg::core_state_t st_nxt; // next state
  logic wrap; // count at its end value

  // next state, moves only on a tick or a clear
  always_comb
  begin
    st_nxt = st_r;
    wrap = dir_down_in ? (st_r.count == 8'h00)
                       : (st_r.count == period_in);
    if (clear_in)
    begin
      st_nxt = '0; // soft reset
    end
    else if (tick_in && retrigger_in)
    begin
      st_nxt.running = 1'b1; // start or restart
      st_nxt.count = dir_down_in ? period_in : 8'h00;
    end
    else if (tick_in && stop_in)
    begin
      st_nxt.running = 1'b0; // forced stop
    end
    else if (tick_in && st_r.running)
    begin
      if (wrap)
      begin
        // wrap around; halt here when single run
        st_nxt.count = dir_down_in ? period_in : 8'h00;
        st_nxt.running = !single_run_in;
      end
      else if (dir_down_in)
      begin
        st_nxt.count = st_r.count - 8'h01;
      end
      else
      begin
        st_nxt.count = st_r.count + 8'h01;
      end
    end
  end

  // register the state
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_r <= '0;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  assign count_out = st_r.count;
  assign running_out = st_r.running;
endmodule // timer_count_core
`default_nettype wire

/* File: logic/timer_control_set_clear.sv */
// timer control with set/clear register pair on an Avalon-MM slave
// Contract
// - set register at index 0x05 sets control
// - commands execute on next prescaled tick
// - command field reads zero once executed
// - 1 retrigger, 2 stop, 3 reserved
// - writing command zero changes nothing
// - clear-side command ones cancel pending command
// - single run halts at next wrap
// - clear-side one disables single run
// - clear-side one on direction counts up
// - clear ones clear, set ones set
// - set and clear read back identical
// - clear wins when both written together
// - reserved bits read zero
// - reset to 0x00, also on soft reset
// - accesses handshaked, pair and period writes guarded
// - read-only ignores writes
`timescale 1ns/1ns
`default_nettype none
module timer_control_set_clear #(
  parameter int unsigned PRESCALE_DIV = timer_ctrl_pkg::PRESCALE_DIV_DEF
) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic [9:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  output logic [7:0] count_value_out,
  output logic counter_running_out
);
  // ==========================================================
  // reset image of the whole state
  localparam timer_ctrl_pkg::main_state_t MAIN_RESET = '{
    bus: timer_ctrl_pkg::BUS_IDLE,
    waitreq: 1'b1,
    rdata: 32'h0000_0000,
    cmd_pend: timer_ctrl_pkg::CMD_NONE,
    single_run: 1'b0,
    dir_down: 1'b0,
    period: timer_ctrl_pkg::PERIOD_RESET,
    enable: 1'b0,
    guard: 1'b0,
    swrst: 1'b0
  };

  // ==========================================================
  // declarations
  timer_ctrl_pkg::main_state_t st_r; // registered state
  timer_ctrl_pkg::main_state_t st_nxt; // next state
  logic tick; // prescaled timer tick
  logic [7:0] core_count; // live count
  logic core_running; // counter running
  logic wr_commit; // write takes effect now
  logic rd_start; // read request seen in idle
  logic [7:0] set_mask; // ones written to set view
  logic [7:0] clr_mask; // ones written to clear view
  logic [1:0] set_cmd; // command field of a set write
  logic cfg_wr; // config write
  logic period_wr; // period write
  logic retrigger_go; // retrigger executes this tick
  logic stop_go; // stop executes this tick

  // address decode against a register index
  function automatic logic reg_hit(input logic [9:0] addr,
                                   input logic [7:0] idx);
    reg_hit = (addr == {idx, 2'b00});
  endfunction

  // control byte image, shared by both views
  function automatic logic [7:0] ctrl_image(
    input timer_ctrl_pkg::main_state_t s);
    ctrl_image = timer_ctrl_pkg::CTRL_RESET;
    ctrl_image[timer_ctrl_pkg::CMD_LSB +: 2] = s.cmd_pend;
    ctrl_image[timer_ctrl_pkg::SINGLE_RUN_POS] = s.single_run;
    ctrl_image[timer_ctrl_pkg::DIR_POS] = s.dir_down;
  endfunction

  // ==========================================================
  // next state logic
  always_comb
  begin
    logic [7:0] rd_byte;
    rd_byte = 8'h00;
    st_nxt = st_r;
    st_nxt.swrst = 1'b0;
    // a write lands only on the edge where waitrequest is low
    wr_commit = (st_r.bus == timer_ctrl_pkg::BUS_ACK) && avs_write_in
                && avs_byteenable_in[0];
    rd_start = (st_r.bus == timer_ctrl_pkg::BUS_IDLE) && avs_read_in;
    // guarded pair writes are dropped
    set_mask = (wr_commit && !st_r.guard
                && reg_hit(avs_address_in, timer_ctrl_pkg::IDX_SET))
               ? avs_writedata_in[7:0] : 8'h00;
    clr_mask = (wr_commit && !st_r.guard
                && reg_hit(avs_address_in, timer_ctrl_pkg::IDX_CLEAR))
               ? avs_writedata_in[7:0] : 8'h00;
    set_cmd = set_mask[timer_ctrl_pkg::CMD_LSB +: 2];
    cfg_wr = wr_commit
             && reg_hit(avs_address_in, timer_ctrl_pkg::IDX_CONFIG);
    period_wr = wr_commit && !st_r.guard
                && reg_hit(avs_address_in, timer_ctrl_pkg::IDX_PERIOD);
    // commands fire only on a tick
    retrigger_go = tick
                   && (st_r.cmd_pend == timer_ctrl_pkg::CMD_RETRIGGER);
    stop_go = tick && (st_r.cmd_pend == timer_ctrl_pkg::CMD_STOP);

    // bus handshake
    case (st_r.bus)
      timer_ctrl_pkg::BUS_IDLE:
      begin
        if (avs_read_in || avs_write_in)
        begin
          st_nxt.bus = timer_ctrl_pkg::BUS_ACK;
          st_nxt.waitreq = 1'b0;
        end
      end
      timer_ctrl_pkg::BUS_ACK:
      begin
        st_nxt.bus = timer_ctrl_pkg::BUS_IDLE;
        st_nxt.waitreq = 1'b1;
      end
      default:
      begin
        st_nxt.bus = timer_ctrl_pkg::BUS_IDLE;
        st_nxt.waitreq = 1'b1;
      end
    endcase

    // read mux, unmapped and reserved read zero
    if (rd_start)
    begin
      if (reg_hit(avs_address_in, timer_ctrl_pkg::IDX_SET)
          || reg_hit(avs_address_in, timer_ctrl_pkg::IDX_CLEAR))
      begin
        rd_byte = ctrl_image(st_r);
      end
      else if (reg_hit(avs_address_in, timer_ctrl_pkg::IDX_CONFIG))
      begin
        rd_byte[timer_ctrl_pkg::CFG_ENABLE_POS] = st_r.enable;
        rd_byte[timer_ctrl_pkg::CFG_GUARD_POS] = st_r.guard;
      end
      else if (reg_hit(avs_address_in, timer_ctrl_pkg::IDX_PERIOD))
      begin
        rd_byte = st_r.period;
      end
      else if (reg_hit(avs_address_in, timer_ctrl_pkg::IDX_COUNT))
      begin
        rd_byte = core_count;
      end
      else if (reg_hit(avs_address_in, timer_ctrl_pkg::IDX_STATUS))
      begin
        rd_byte = {6'h00,
                   st_r.cmd_pend != timer_ctrl_pkg::CMD_NONE,
                   core_running};
      end
      st_nxt.rdata = {24'h00_0000, rd_byte};
    end

    // executed command clears the pending field
    if (tick)
    begin
      st_nxt.cmd_pend = timer_ctrl_pkg::CMD_NONE;
    end
    // set view: only live codes load, 0 and 3 leave the pending command as is
    if (set_cmd == timer_ctrl_pkg::CMD_RETRIGGER
        || set_cmd == timer_ctrl_pkg::CMD_STOP)
    begin
      st_nxt.cmd_pend = timer_ctrl_pkg::cmd_t'(set_cmd);
    end
    else if (set_cmd == timer_ctrl_pkg::CMD_NONE && !tick)
    begin
      st_nxt.cmd_pend = st_r.cmd_pend;
    end
    // clear view: any command one cancels what waits
    if (clr_mask[timer_ctrl_pkg::CMD_LSB +: 2] != 2'b00)
    begin
      st_nxt.cmd_pend = timer_ctrl_pkg::CMD_NONE;
    end
    // set ones set, clear ones clear, clear applied last
    st_nxt.single_run =
      (st_r.single_run | set_mask[timer_ctrl_pkg::SINGLE_RUN_POS])
      & ~clr_mask[timer_ctrl_pkg::SINGLE_RUN_POS];
    st_nxt.dir_down =
      (st_r.dir_down | set_mask[timer_ctrl_pkg::DIR_POS])
      & ~clr_mask[timer_ctrl_pkg::DIR_POS];

    // config and period
    if (cfg_wr)
    begin
      st_nxt.enable = avs_writedata_in[timer_ctrl_pkg::CFG_ENABLE_POS];
      st_nxt.guard = avs_writedata_in[timer_ctrl_pkg::CFG_GUARD_POS];
      st_nxt.swrst = avs_writedata_in[timer_ctrl_pkg::CFG_SWRST_POS];
    end
    if (period_wr)
    begin
      st_nxt.period = avs_writedata_in[7:0];
    end

    // soft reset returns control to reset values
    if (st_r.swrst)
    begin
      st_nxt.cmd_pend = timer_ctrl_pkg::CMD_NONE;
      st_nxt.single_run = 1'b0;
      st_nxt.dir_down = 1'b0;
      st_nxt.period = timer_ctrl_pkg::PERIOD_RESET;
      st_nxt.enable = 1'b0;
    end
  end

  // register the state
  always_ff @(posedge ref_clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      st_r <= MAIN_RESET;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // ==========================================================
  // tick source and counter
  timer_tick_prescaler #(
    .DIV(PRESCALE_DIV)
  ) u_prescaler (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .enable_in(st_r.enable),
    .clear_in(st_r.swrst),
    .tick_out(tick)
  );

  timer_count_core u_core (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .tick_in(tick),
    .clear_in(st_r.swrst),
    .retrigger_in(retrigger_go),
    .stop_in(stop_go),
    .dir_down_in(st_r.dir_down),
    .single_run_in(st_r.single_run),
    .period_in(st_r.period),
    .count_out(core_count),
    .running_out(core_running)
  );

  // outputs straight from flops
  assign avs_readdata_out = st_r.rdata;
  assign avs_waitrequest_out = st_r.waitreq;
  assign count_value_out = core_count;
  assign counter_running_out = core_running;

  // ==========================================================
  // assertions
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);

  sequence s_req_idle;
    (st_r.bus == timer_ctrl_pkg::BUS_IDLE)
    && (avs_read_in || avs_write_in);
  endsequence
  sequence s_one_ack;
    !avs_waitrequest_out ##1 avs_waitrequest_out;
  endsequence

  property p_handshake;
    s_req_idle |=> s_one_ack;
  endproperty
  a_handshake: assert property (p_handshake)
    else $error("waitrequest not low for exactly one cycle");
  property p_cmd_exec;
    tick && st_r.cmd_pend != timer_ctrl_pkg::CMD_NONE
    && set_cmd == 2'h0 |=> st_r.cmd_pend == timer_ctrl_pkg::CMD_NONE;
  endproperty
  a_cmd_exec: assert property (p_cmd_exec)
    else $error("command field not zero after execution");
  property p_cmd_wait;
    !tick && set_cmd == 2'h0 && clr_mask == 8'h00 && !st_r.swrst
    |=> $stable(st_r.cmd_pend);
  endproperty
  a_cmd_wait: assert property (p_cmd_wait)
    else $error("pending command changed without a tick");
  property p_retrig;
    retrigger_go && !st_r.swrst |=> core_running;
  endproperty
  a_retrig: assert property (p_retrig)
    else $error("retrigger did not start the counter");
  property p_reserved_cmd;
    set_cmd == 2'h3 && !tick && clr_mask == 8'h00 && !st_r.swrst
    |=> $stable(st_r.cmd_pend);
  endproperty
  a_reserved_cmd: assert property (p_reserved_cmd)
    else $error("reserved command changed the pending command");
  property p_set_dir;
    set_mask[0] && !clr_mask[0] && !st_r.swrst |=> st_r.dir_down;
  endproperty
  a_set_dir: assert property (p_set_dir)
    else $error("set write did not set the direction bit");
  property p_clr_single;
    clr_mask[2] |=> !st_r.single_run;
  endproperty
  a_clr_single: assert property (p_clr_single)
    else $error("clear write did not disable single run");

  property p_pair_read;
    rd_start && (reg_hit(avs_address_in, timer_ctrl_pkg::IDX_SET)
    || reg_hit(avs_address_in, timer_ctrl_pkg::IDX_CLEAR))
    |=> avs_readdata_out[7:0] == ctrl_image($past(st_r));
  endproperty
  a_pair_read: assert property (p_pair_read)
    else $error("set and clear views read differently");

  property p_reserved_zero;
    !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h00_0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("reserved read bits not zero");

  property p_soft_reset;
    st_r.swrst |=> ctrl_image(st_r) == timer_ctrl_pkg::CTRL_RESET
                   || $past(wr_commit);
  endproperty
  a_soft_reset: assert property (p_soft_reset)
    else $error("soft reset left control bits set");
endmodule // timer_control_set_clear
`default_nettype wire

/* File: bench/timer_control_set_clear_test.sv */
// self-checking testbench of the timer control set/clear register pair
`timescale 1ns/1ns
`default_nettype none
module timer_control_set_clear_test;
  // ==========================================================
  // settings and bench signals
  localparam int unsigned DIV = 2; // short prescaler for quick runs
  localparam int LIMIT = 4000; // cycle ceiling of the whole run
  localparam logic [7:0] IDX_UNMAPPED = 8'h3F; // no register here
  logic ref_clk_in; // 25 MHz bench clock
  logic arst_n_in; // async reset, active low
  logic [9:0] avs_address_in; // byte address
  logic avs_read_in;
  logic avs_write_in;
  logic [31:0] avs_writedata_in;
  logic [3:0] avs_byteenable_in;
  logic [31:0] avs_readdata_out;
  logic avs_waitrequest_out;
  logic [7:0] count_value_out;
  logic counter_running_out;
  int miscompares; // mismatches seen
  int checked; // comparisons made
  int cycles = 0; // clock cycles since start

  // ==========================================================
  // device under test
  timer_control_set_clear #(
    .PRESCALE_DIV(DIV)
  ) uut (
    .ref_clk_in(ref_clk_in),
    .arst_n_in(arst_n_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .count_value_out(count_value_out),
    .counter_running_out(counter_running_out)
  );

  // ==========================================================
  // clock, 40 ns period
  initial
  begin
    ref_clk_in = 1'b0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end

  // hang guard: count cycles, stop the run at the ceiling
  always @(posedge ref_clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == LIMIT)
    begin
      $display("[ERR] %0t run timed out", $time);
      miscompares = miscompares + 1;
      end_of_test();
    end
  end

  // ==========================================================
  // helpers
  // verdict and end of run
  task automatic end_of_test();
    if (miscompares == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // compare one byte, report and count
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked = checked + 1;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
      miscompares = miscompares + 1;
    end
  endtask

  // one avalon access; held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] idx,
                     input logic [7:0] wd, input logic [3:0] be,
                     output logic [7:0] rd);
    int n;
    n = 0;
    @(posedge ref_clk_in);
    avs_address_in <= {idx, 2'b00};
    avs_read_in <= ~wr;
    avs_write_in <= wr;
    avs_writedata_in <= {24'h00_0000, wd};
    avs_byteenable_in <= be;
    // wait for the answer edge, bounded
    do
    begin
      @(posedge ref_clk_in);
      n = n + 1;
    end
    while (avs_waitrequest_out !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      $display("[ERR] %0t no bus answer", $time);
      miscompares = miscompares + 1;
    end
    rd = avs_readdata_out[7:0];
    avs_read_in <= 1'b0;
    avs_write_in <= 1'b0;
  endtask

  // register write
  task automatic wr(input logic [7:0] idx, input logic [7:0] wd);
    logic [7:0] unused;
    bus(1'b1, idx, wd, 4'h1, unused);
  endtask

  // register read and compare
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] got;
    bus(1'b0, idx, 8'h00, 4'h1, got);
    chk(got, exp);
  endtask

  // let some clock cycles pass
  task automatic idle(input int n);
    repeat (n) @(posedge ref_clk_in);
  endtask

  // ==========================================================
  // scenarios
  // values after reset, unmapped read
  task automatic t_reset();
    rd(timer_ctrl_pkg::IDX_SET, 8'h00);
    rd(timer_ctrl_pkg::IDX_CLEAR, 8'h00);
    rd(timer_ctrl_pkg::IDX_PERIOD, 8'hFF);
    rd(IDX_UNMAPPED, 8'h00);
  endtask

  // set and clear views of the control byte
  task automatic t_set_clear();
    wr(timer_ctrl_pkg::IDX_SET, 8'h05);
    rd(timer_ctrl_pkg::IDX_SET, 8'h05);
    rd(timer_ctrl_pkg::IDX_CLEAR, 8'h05);
    wr(timer_ctrl_pkg::IDX_CLEAR, 8'h00);
    rd(timer_ctrl_pkg::IDX_SET, 8'h05);
    wr(timer_ctrl_pkg::IDX_CLEAR, 8'h01);
    rd(timer_ctrl_pkg::IDX_SET, 8'h04);
    wr(timer_ctrl_pkg::IDX_CLEAR, 8'h04);
    rd(timer_ctrl_pkg::IDX_CLEAR, 8'h00);
    wr(timer_ctrl_pkg::IDX_SET, 8'h3A);
    rd(timer_ctrl_pkg::IDX_SET, 8'h00);
  endtask

  // commands pend without ticks, cancel, execute, stop
  task automatic t_commands();
    wr(timer_ctrl_pkg::IDX_CONFIG, 8'h00);
    wr(timer_ctrl_pkg::IDX_SET, 8'h40);
    rd(timer_ctrl_pkg::IDX_SET, 8'h40);
    rd(timer_ctrl_pkg::IDX_STATUS, 8'h02);
    wr(timer_ctrl_pkg::IDX_SET, 8'hC0);
    rd(timer_ctrl_pkg::IDX_SET, 8'h40);
    wr(timer_ctrl_pkg::IDX_SET, 8'h00);
    rd(timer_ctrl_pkg::IDX_SET, 8'h40);
    wr(timer_ctrl_pkg::IDX_CLEAR, 8'h40);
    rd(timer_ctrl_pkg::IDX_SET, 8'h00);
    rd(timer_ctrl_pkg::IDX_STATUS, 8'h00);
    // retrigger, then let ticks run
    wr(timer_ctrl_pkg::IDX_SET, 8'h40);
    wr(timer_ctrl_pkg::IDX_CONFIG, 8'h01);
    idle(3 * DIV);
    rd(timer_ctrl_pkg::IDX_SET, 8'h00);
    chk({7'h00, counter_running_out}, 8'h01);
    wr(timer_ctrl_pkg::IDX_SET, 8'h80);
    idle(3 * DIV);
    chk({7'h00, counter_running_out}, 8'h00);
  endtask

  // single run halts at the wrap, continuous mode keeps going
  task automatic t_single_run();
    wr(timer_ctrl_pkg::IDX_PERIOD, 8'h03);
    wr(timer_ctrl_pkg::IDX_SET, 8'h04);
    wr(timer_ctrl_pkg::IDX_SET, 8'h40);
    idle(12 * DIV);
    chk({7'h00, counter_running_out}, 8'h00);
    wr(timer_ctrl_pkg::IDX_CLEAR, 8'h04);
    wr(timer_ctrl_pkg::IDX_SET, 8'h40);
    idle(12 * DIV);
    chk({7'h00, counter_running_out}, 8'h01);
    chk({7'h00, count_value_out <= 8'h03}, 8'h01);
    wr(timer_ctrl_pkg::IDX_SET, 8'h80);
  endtask

  // write guard drops set writes
  task automatic t_guard();
    logic [7:0] unused; // read data of a write, ignored
    wr(timer_ctrl_pkg::IDX_CONFIG, 8'h04);
    wr(timer_ctrl_pkg::IDX_SET, 8'h01);
    rd(timer_ctrl_pkg::IDX_SET, 8'h00);
    wr(timer_ctrl_pkg::IDX_CONFIG, 8'h00);
    wr(timer_ctrl_pkg::IDX_SET, 8'h01);
    rd(timer_ctrl_pkg::IDX_SET, 8'h01);
    // a write with byte lane 0 off must not land
    bus(1'b1, timer_ctrl_pkg::IDX_CLEAR, 8'h01, 4'h0, unused);
    rd(timer_ctrl_pkg::IDX_SET, 8'h01);
  endtask

  // soft reset restores values, read-only count ignores writes
  task automatic t_soft_reset();
    wr(timer_ctrl_pkg::IDX_SET, 8'h05);
    wr(timer_ctrl_pkg::IDX_CONFIG, 8'h02);
    rd(timer_ctrl_pkg::IDX_SET, 8'h00);
    rd(timer_ctrl_pkg::IDX_PERIOD, 8'hFF);
    rd(timer_ctrl_pkg::IDX_COUNT, 8'h00);
    wr(timer_ctrl_pkg::IDX_COUNT, 8'hAA);
    rd(timer_ctrl_pkg::IDX_COUNT, 8'h00);
  endtask

  // ==========================================================
  // main sequence: reset for five cycles, then the scenarios
  initial
  begin
    miscompares = 0;
    checked = 0;
    arst_n_in = 1'b0;
    avs_address_in = 10'h000;
    avs_read_in = 1'b0;
    avs_write_in = 1'b0;
    avs_writedata_in = 32'h0000_0000;
    avs_byteenable_in = 4'h0;
    idle(5);
    arst_n_in <= 1'b1;
    t_reset();
    t_set_clear();
    t_commands();
    t_single_run();
    t_guard();
    t_soft_reset();
    end_of_test();
  end
endmodule // timer_control_set_clear_test
`default_nettype wire
